// File: hw/usu_map.vh
`ifndef USU_MAP_VH
`define USU_MAP_VH
// Data register width and counter width.
`define USU_DATA_W 8
`define USU_CNT_W 4
// Reset values.
`define USU_DATA_RST 8'h00
`define USU_CNT_RST 4'h0
// Counter value at which the next clock wraps it.
`define USU_CNT_MAX 4'hF
// Wire mode encodings of the two mode bits.
`define USU_WM_OFF 2'h0
`define USU_WM_THREE 2'h1
`define USU_WM_TWO 2'h2
`define USU_WM_TWO_HOLD 2'h3
// Clock source select encodings: {clock_source_select, external_edge_select}.
`define USU_CS_SOFT 2'h0
`define USU_CS_TIMER 2'h1
`define USU_CS_EXT_POS 2'h2
`define USU_CS_EXT_NEG 2'h3
`endif

// File: hw/usu_sync.v
`timescale 1ns/1ps
`default_nettype none
// Two flip-flop synchroniser for one level from outside the clock domain.
module usu_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_n,
  input  wire ce,
  input  wire d,
  output reg  q
);
  reg meta_q;

  // The first stage feeds only the second stage.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q      <= RST_VAL;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: hw/usu_top.v
`timescale 1ns/1ps
`default_nettype none
`include "usu_map.vh"
////////////////////////////////////////////////////////////////////////////////
module usu_top #(
  parameter DATA_W = `USU_DATA_W,
  parameter CNT_W  = `USU_CNT_W
) (
  input  wire              clk,
  input  wire              rstn,
  input  wire              ce,
  input  wire [1:0]        wire_mode,
  input  wire              clock_source_select,
  input  wire              external_edge_select,
  input  wire              software_clock_strobe,
  input  wire              clock_toggle_strobe,
  input  wire              timer_compare_match,
  input  wire              data_wr,
  input  wire [DATA_W-1:0] data_wdata,
  output reg  [DATA_W-1:0] shift_data_q,
  input  wire              cnt_wr,
  input  wire [CNT_W-1:0]  cnt_wdata,
  output reg  [CNT_W-1:0]  cnt_q,
  input  wire              ovf_clr,
  output reg               counter_overflow_flag,
  input  wire              start_clr,
  output reg               start_flag,
  output wire              ovf_irq,
  output wire              start_irq,
  input  wire              serial_data_in,
  input  wire              serial_clock_pin,
  input  wire              serial_clock_pin_port,
  output reg               serial_clock_pin_out,
  output wire              serial_clock_pin_oe,
  output reg               serial_data_out,
  output reg               two_wire_data_out,
  output wire              two_wire_data_oe,
  output wire              rx_valid,
  input  wire              rx_ready,
  output wire [DATA_W-1:0] rx_data
);
  ////////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.
  reg  rst_meta_q;
  reg  rst_n_q;
  wire din_s;
  wire sck_s;
  reg  sck_prev_q;

  // Reset is asserted at once and released through two flip-flops.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // The data input resets high, its idle two-wire level, so no false start follows reset.
  usu_sync #(.RST_VAL(1'b1)) u_sync_din (
    .clk   (clk),
    .rst_n (rst_n_q),
    .ce    (ce),
    .d     (serial_data_in),
    .q     (din_s)
  );

  usu_sync #(.RST_VAL(1'b0)) u_sync_sck (
    .clk   (clk),
    .rst_n (rst_n_q),
    .ce    (ce),
    .d     (serial_clock_pin),
    .q     (sck_s)
  );

  // Previous synchronised clock level for edge detection.
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sck_prev_q <= 1'b0;
    end else if (ce) begin
      sck_prev_q <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock source selection.
  wire [1:0] cs_sel;
  wire       sck_rise;
  wire       sck_fall;
  wire       ext_src;
  reg        shift_clk;
  reg        cnt_clk;

  assign cs_sel   = {clock_source_select, external_edge_select};
  assign sck_rise = sck_s & ~sck_prev_q;
  assign sck_fall = ~sck_s & sck_prev_q;
  assign ext_src  = clock_source_select;

  // Select the shift clock and the counter clock from one source.
  always @* begin
    shift_clk = 1'b0;
    cnt_clk   = 1'b0;
    case (cs_sel)
      `USU_CS_SOFT: begin
        shift_clk = software_clock_strobe;
        cnt_clk   = software_clock_strobe;
      end
      `USU_CS_TIMER: begin
        shift_clk = timer_compare_match;
        cnt_clk   = timer_compare_match;
      end
      `USU_CS_EXT_POS: begin
        shift_clk = sck_rise;
        cnt_clk   = sck_rise | sck_fall;
      end
      `USU_CS_EXT_NEG: begin
        shift_clk = sck_fall;
        cnt_clk   = sck_rise | sck_fall;
      end
      default: begin
        shift_clk = 1'b0;
        cnt_clk   = 1'b0;
      end
    endcase
    // The software strobe also counts when an external pin clock source is chosen.
    if (ext_src && software_clock_strobe) begin
      cnt_clk = 1'b1;
    end
  end

  // Word handed to the buffer at a wrap. In mode 0 the wrapping edge does not
  // shift, so the register already holds the byte; otherwise take the shifted value.
  wire [DATA_W-1:0] rx_word;

  assign rx_word = (shift_clk & ~data_wr) ? {shift_data_q[DATA_W-2:0], din_s}
                                          : shift_data_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift register; write wins over a coincident shift.
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shift_data_q <= `USU_DATA_RST;
    end else if (ce) begin
      if (data_wr) begin
        shift_data_q <= data_wdata;
      end else if (shift_clk) begin
        shift_data_q <= {shift_data_q[DATA_W-2:0], din_s};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and overflow flag; a wrap beats a software clear.
  wire cnt_wrap;

  assign cnt_wrap = cnt_clk & (cnt_q == `USU_CNT_MAX) & ~cnt_wr;

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q                 <= `USU_CNT_RST;
      counter_overflow_flag <= 1'b0;
    end else if (ce) begin
      if (cnt_wr) begin
        cnt_q <= cnt_wdata;
      end else if (cnt_clk) begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (cnt_wrap) begin
        counter_overflow_flag <= 1'b1;
      end else if (ovf_clr) begin
        counter_overflow_flag <= 1'b0;
      end
    end
  end

  // Overflow request is a level usable as an idle wake-up source.
  assign ovf_irq = counter_overflow_flag;

  ////////////////////////////////////////////////////////////////////////////////
  // Output latch: open in the first half of an external clock, else always.
  wire latch_open;
  wire two_wire;

  assign two_wire   = wire_mode[1];
  assign latch_open = ~ext_src | (sck_s == external_edge_select);

  // Latch modelled as a clocked enable so the pin moves on the opposite edge.
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      serial_data_out   <= 1'b0;
      two_wire_data_out <= 1'b0;
    end else if (ce) begin
      if (latch_open) begin
        serial_data_out   <= (wire_mode == `USU_WM_THREE) & shift_data_q[DATA_W-1];
        two_wire_data_out <= shift_data_q[DATA_W-1];
      end
    end
  end

  // Open-drain data pin pulls low only when the top bit is zero.
  assign two_wire_data_oe = two_wire & ~two_wire_data_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Two-wire start detector and clock hold.
  reg din_prev_q;
  reg hold_q;
  wire start_det;

  assign start_det = two_wire & sck_s & sck_prev_q & din_prev_q & ~din_s;

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      din_prev_q <= 1'b1;
      start_flag <= 1'b0;
      hold_q     <= 1'b0;
    end else if (ce) begin
      din_prev_q <= din_s;
      if (start_det) begin
        start_flag <= 1'b1;
      end else if (start_clr) begin
        start_flag <= 1'b0;
      end
      if (start_det || (cnt_wrap && wire_mode == `USU_WM_TWO_HOLD)) begin
        hold_q <= 1'b1;
      end else if (!start_flag && !(counter_overflow_flag && wire_mode == `USU_WM_TWO_HOLD)) begin
        hold_q <= 1'b0;
      end
    end
  end

  assign start_irq = start_flag;

  // Clock pin: toggled by strobe or port, forced low by a two-wire hold.
  reg sck_tog_q;

  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sck_tog_q            <= 1'b0;
      serial_clock_pin_out <= 1'b0;
    end else if (ce) begin
      if (clock_toggle_strobe) begin
        sck_tog_q <= ~sck_tog_q;
      end
      serial_clock_pin_out <= (sck_tog_q ^ serial_clock_pin_port) & ~(two_wire & hold_q);
    end
  end

  // Without hardware slave select the pin is driven during a two-wire hold, or outside two-wire mode when master or toggled high.
  assign serial_clock_pin_oe = (two_wire & hold_q) | (~two_wire & (sck_tog_q | ~ext_src));

  ////////////////////////////////////////////////////////////////////////////////
  // Two-entry receive buffer loaded on each overflow that finds it not full.
  usu_fifo2 #(.W(DATA_W)) u_rx (
    .clk     (clk),
    .rst_n   (rst_n_q),
    .ce      (ce),
    .in_valid(cnt_wrap),
    .in_ready(),
    .in_data (rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
endmodule

////////////////////////////////////////////////////////////////////////////////
// Two-entry buffer with valid and ready on both sides.
module usu_fifo2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid & in_ready & ce;
  assign pop       = out_valid & out_ready & ce;

  // Pointers and occupancy; a full buffer drops the newest word.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= {W{1'b0}};
      mem_q[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/usu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Watches counter, shift register, flag and buffer behaviour at the top ports.
module usu_monitor #(
  parameter DATA_W = 8,
  parameter CNT_W  = 4
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              ce,
  input wire logic              clock_source_select,
  input wire logic              external_edge_select,
  input wire logic              software_clock_strobe,
  input wire logic              data_wr,
  input wire logic [DATA_W-1:0] data_wdata,
  input wire logic [DATA_W-1:0] shift_data_q,
  input wire logic              cnt_wr,
  input wire logic [CNT_W-1:0]  cnt_wdata,
  input wire logic [CNT_W-1:0]  cnt_q,
  input wire logic              ovf_clr,
  input wire logic              counter_overflow_flag,
  input wire logic              ovf_irq,
  input wire logic              rx_valid,
  input wire logic              rx_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A plain software strobe step with no competing register write.
  wire step = ce && !clock_source_select && !external_edge_select
              && software_clock_strobe && !data_wr && !cnt_wr;
  // The step that wraps a full counter.
  sequence s_wrap;
    step && (&cnt_q);
  endsequence
  property p_ovf;
    s_wrap |-> ##[1:2] counter_overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("wrap left overflow flag low");
  property p_irq;
    ovf_irq == counter_overflow_flag;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow request differs from flag");
  property p_wr;
    ce && data_wr |=> shift_data_q == $past(data_wdata);
  endproperty
  a_wr: assert property (p_wr) else $error("data write not stored");
  property p_cwr;
    ce && cnt_wr |=> cnt_q == $past(cnt_wdata);
  endproperty
  a_cwr: assert property (p_cwr) else $error("counter write not stored");
  property p_step;
    step |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1)
      && shift_data_q[DATA_W-1:1] == $past(shift_data_q[DATA_W-2:0]);
  endproperty
  a_step: assert property (p_step) else $error("strobe did not shift and count");
  property p_clr;
    ce && ovf_clr && !(&cnt_q) |=> !counter_overflow_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("overflow flag not cleared");
  property p_hold;
    counter_overflow_flag && !ovf_clr |=> counter_overflow_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("overflow flag dropped alone");
  property p_buf;
    rx_valid && !rx_ready |=> rx_valid;
  endproperty
  a_buf: assert property (p_buf) else $error("buffered byte lost in stall");
endmodule

bind usu_top usu_monitor #(.DATA_W(DATA_W), .CNT_W(CNT_W)) i_usu_monitor (
  .clk(clk), .rstn(rstn), .ce(ce), .clock_source_select(clock_source_select),
  .external_edge_select(external_edge_select), .software_clock_strobe(software_clock_strobe),
  .data_wr(data_wr), .data_wdata(data_wdata), .shift_data_q(shift_data_q), .cnt_wr(cnt_wr),
  .cnt_wdata(cnt_wdata), .cnt_q(cnt_q), .ovf_clr(ovf_clr),
  .counter_overflow_flag(counter_overflow_flag), .ovf_irq(ovf_irq), .rx_valid(rx_valid),
  .rx_ready(rx_ready)
);
`default_nettype wire

// File: test/usu_spi_master.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Far side master: clock idles low between frames, data parked.
module usu_spi_master (
  output logic      sck,
  output logic      mosi,
  input  wire logic miso
);
  // Idle levels.
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
  end
  // One byte MSB first at 64 ns; mode 0 samples rising, mode 1 falling.
  task automatic xfer(input logic md, input logic [7:0] tx, output logic [7:0] rx);
    int i;
    for (i = 7; i >= 0; i--) begin
      if (!md) mosi = tx[i];
      #32 sck = 1'b1;
      if (!md) rx = {rx[6:0], miso};
      else mosi = tx[i];
      #32 sck = 1'b0;
      if (md) rx = {rx[6:0], miso};
    end
    // Hold past the last sample, then park the line on a changed level.
    #16 mosi = ~mosi;
  endtask
  // Holds the clock pin at a chosen level between frames.
  task automatic park(input logic v);
    sck = v;
  endtask
endmodule
`default_nettype wire

// File: test/tb_usu_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Bench for strobe, timer and pin clocked transfers with a stalled buffer.
module tb_usu_top;
  logic       clk, rstn, ce, sel, edg, stb, tmr, dwr, cwr, oclr, rrdy, din;
  logic       tgl, prt, sclr;
  logic [1:0] wm;
  logic [7:0] wd;
  logic [3:0] cwd;
  logic [7:0] q[$];
  wire        sck, mosi, dout, of, rv;
  wire        sf, sirq, oirq, sco, scoe, tdo, tdoe;
  wire  [7:0] sq, rd;
  wire  [3:0] cq;
  int         fails, tests_run, ncyc;
  usu_top i_usu_top (
    .clk(clk), .rstn(rstn), .ce(ce), .wire_mode(wm), .clock_source_select(sel),
    .external_edge_select(edg), .software_clock_strobe(stb), .clock_toggle_strobe(tgl),
    .timer_compare_match(tmr), .data_wr(dwr), .data_wdata(wd), .shift_data_q(sq),
    .cnt_wr(cwr), .cnt_wdata(cwd), .cnt_q(cq), .ovf_clr(oclr), .counter_overflow_flag(of),
    .start_clr(sclr), .start_flag(sf), .ovf_irq(oirq), .start_irq(sirq),
    .serial_data_in(sel ? mosi : din), .serial_clock_pin(sck), .serial_clock_pin_port(prt),
    .serial_clock_pin_out(sco), .serial_clock_pin_oe(scoe), .serial_data_out(dout),
    .two_wire_data_out(tdo), .two_wire_data_oe(tdoe), .rx_valid(rv), .rx_ready(rrdy),
    .rx_data(rd)
  );
  usu_spi_master i_usu_spi_master (.sck(sck), .mosi(mosi), .miso(dout));
  // Core clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    tests_run++;
    if (a !== e) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  // Pin clocked byte: load, clear counter and flag, let the master run.
  task automatic ext(input logic md, input logic acc);
    logic [7:0] d, m, r;
    d = $urandom;
    m = $urandom;
    sel = 1'b1;
    edg = md;
    wd = d;
    pulse(dwr);
    cwd = 4'h0;
    pulse(cwr);
    pulse(oclr);
    if (acc) q.push_back(m);
    cyc(4);
    #1.3 i_usu_spi_master.xfer(md, m, r);
    cyc(8);
    chk(r, d);
    chk(sq, m);
    chk({4'h0, cq}, 8'h00);
    chk({7'h00, of}, 8'h01);
    $display("test pin mode %0d done", md);
  endtask
  // Each byte leaving the buffer is matched against the oldest expected one.
  always @(posedge clk) begin
    if (rv === 1'b1 && rrdy) chk(rd, q.size() ? q.pop_front() : 8'hXX);
  end
  // Cuts a hang short.
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  // Main sequence.
  initial begin
    logic [7:0] d, e;
    int i;
    {ce, sel, edg, stb, tmr, dwr, cwr, oclr, din, rstn, tgl, prt, sclr} = '0;
    rrdy = 1'b1;
    wm = 2'h1;
    wd = 8'h00;
    cwd = 4'h0;
    void'($urandom(26));
    cyc(10);
    rstn = 1'b1;
    cyc(3);
    ce = 1'b1;
    chk(sq, 8'h00);
    chk({4'h0, cq}, 8'h00);
    d = $urandom;
    e = $urandom;
    wd = d;
    pulse(dwr);
    cwd = 4'h8;
    pulse(cwr);
    q.push_back(e);
    for (i = 7; i >= 0; i--) begin
      din = e[i];
      cyc(4);
      chk({7'h00, dout}, {7'h00, d[i]});
      pulse(stb);
    end
    cyc(4);
    chk(sq, e);
    chk({7'h00, of}, 8'h01);
    pulse(oclr);
    chk({7'h00, of}, 8'h00);
    edg = 1'b1;
    cwd = 4'h2;
    pulse(cwr);
    pulse(tmr);
    chk({4'h0, cq}, 8'h03);
    edg = 1'b0;
    wd = ~d;
    cwd = 4'h5;
    {dwr, cwr, stb} = 3'h7;
    cyc(1);
    {dwr, cwr, stb} = 3'h0;
    chk(sq, ~d);
    chk({4'h0, cq}, 8'h05);
    ce = 1'b0;
    pulse(stb);
    ce = 1'b1;
    chk(sq, ~d);
    $display("test software and timer done");
    ext(1'b0, 1'b1);
    ext(1'b1, 1'b1);
    rrdy = 1'b0;
    ext(1'b0, 1'b1);
    ext(1'b1, 1'b1);
    ext(1'b0, 1'b0);
    rrdy = 1'b1;
    cyc(8);
    chk(q.size(), 8'h00);
    $display("test buffer stall done");
    // Clock pin: toggle strobe and port level both reach the driven clock output.
    sel = 1'b0;
    din = 1'b1;
    cyc(4);
    chk({7'h00, scoe}, 8'h01);
    pulse(tgl);
    cyc(1);
    chk({7'h00, sco}, 8'h01);
    prt = 1'b1;
    cyc(2);
    chk({7'h00, sco}, 8'h00);
    pulse(tgl);
    cyc(1);
    chk({7'h00, sco}, 8'h01);
    $display("test clock pin done");
    // Two-wire: a start condition sets the flag and holds the clock pin low.
    i_usu_spi_master.park(1'b1);
    wm = 2'h2;
    cyc(4);
    chk({7'h00, sf}, 8'h00);
    din = 1'b0;
    cyc(5);
    chk({6'h00, sf, sirq}, 8'h03);
    chk({6'h00, scoe, sco}, 8'h02);
    pulse(sclr);
    cyc(1);
    chk({6'h00, sf, scoe}, 8'h00);
    din = 1'b1;
    wd = 8'h00;
    pulse(dwr);
    cyc(1);
    chk({5'h00, dout, tdo, tdoe}, 8'h01);
    wd = 8'hDA;
    pulse(dwr);
    cyc(1);
    chk({5'h00, dout, tdo, tdoe}, 8'h02);
    // Overflow hold: a wrap in hold mode pulls the clock low until the flag clears.
    wm = 2'h3;
    cwd = 4'hF;
    pulse(cwr);
    q.push_back(8'hB5);
    pulse(stb);
    cyc(1);
    chk({6'h00, of, oirq}, 8'h03);
    chk({6'h00, scoe, sco}, 8'h02);
    pulse(oclr);
    cyc(2);
    chk({6'h00, scoe, sco}, 8'h01);
    $display("test two-wire done");
    // Reset in mid-run returns the registers, flags and buffer to idle.
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(3);
    chk(sq, 8'h00);
    chk({3'h0, cq, of}, 8'h00);
    chk({5'h00, sf, rv, scoe}, 8'h00);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
